/* src/pm_regs.svh */
// Register indices, field positions, reset values and timing constants of the power monitor link
`ifndef PM_REGS_SVH
`define PM_REGS_SVH

// ==========================================
// Clock and conversion periods
`define PM_CLK_MHZ 100
`define PM_T_CONV0_US 13'd50
`define PM_T_CONV1_US 13'd84
`define PM_T_CONV2_US 13'd150
`define PM_T_CONV3_US 13'd280
`define PM_T_CONV4_US 13'd540
`define PM_T_CONV5_US 13'd1052
`define PM_T_CONV6_US 13'd2074
`define PM_T_CONV7_US 13'd4120
`define PM_LINK_HALF 8

// ==========================================
// Device register indices
`define PM_R_CONFIG 7'h00
`define PM_R_ADC_CONFIG 7'h01
`define PM_R_VBUS 7'h05
`define PM_R_TEMP 7'h06
`define PM_R_CURRENT 7'h07
`define PM_R_POWER 7'h08
`define PM_R_ENERGY 7'h09
`define PM_R_CHARGE 7'h0a
`define PM_R_DIAG 7'h0b
`define PM_R_COL 7'h0c
`define PM_R_CUL 7'h0d
`define PM_R_BUS_OVERVOLTAGE_LIMIT 7'h0e
`define PM_R_BUVL 7'h0f
`define PM_R_TOL 7'h10
`define PM_R_POL 7'h11

// ==========================================
// Device fields and reset values
`define PM_CFG_ACC_RST 0
`define PM_CFG_LATCH 1
`define PM_CFG_TRIG 2
`define PM_ADC_CONT 0
`define PM_RST_CONV_SEL 3'h5
`define PM_RST_AVG_SEL 3'h0
`define PM_RST_COL 16'h7fff
`define PM_RST_CUL 16'h8000
`define PM_RST_BUS_OVERVOLTAGE_LIMIT 15'h7fff
`define PM_RST_BUVL 15'h0000
`define PM_RST_TOL 16'h07ff
`define PM_RST_POL 16'h0fff

// ==========================================
// Host controller APB map
`define PM_A_CMD 8'h00
`define PM_A_STATUS 8'h04
`define PM_A_RDATA 8'h08
`define PM_A_IRQ_STAT 8'h0c
`define PM_A_IRQ_CLR 8'h10
`define PM_A_IRQ_EN 8'h14
`define PM_CMD_READ 23

`endif

/* src/pm_pkg.sv */
// Types shared by the power monitor device and its host controller
package pm_pkg;

    // ==========================================
    // Device state
    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
        logic in_frame;
        logic rw;
        logic [4:0] bitcnt;
        logic [6:0] regi;
        logic [15:0] wdat;
        logic [15:0] rdat;
        logic sda_oe_n;
        logic latch;
        logic cont;
        logic trig_busy;
        logic [2:0] conv_sel;
        logic [2:0] avg_sel;
        logic [23:0] timer;
        logic [10:0] navg;
        logic [29:0] sum_cur;
        logic [29:0] sum_vb;
        logic [29:0] sum_tmp;
        logic [19:0] cur;
        logic [19:0] vb;
        logic [15:0] tmp;
        logic [23:0] pwr;
        logic [39:0] energy;
        logic [39:0] charge;
        logic [7:0] diag;
        logic [15:0] col;
        logic [15:0] cul;
        logic [15:0] tol;
        logic [15:0] pol;
        logic [14:0] bus_overvoltage_limit;
        logic [14:0] buvl;
        logic conv_req;
        logic result_valid;
        logic alert;
    } pm_dev_t;

    // ==========================================
    // Host state
    typedef enum logic [2:0] {
        PM_IDLE,
        PM_START,
        PM_LOW,
        PM_HIGH,
        PM_STOP_LOW,
        PM_STOP_HIGH,
        PM_STOP_REL
    } pm_hstate_t;

    typedef struct packed {
        logic sda_m;
        logic sda_s;
        pm_hstate_t st;
        logic [7:0] cnt;
        logic [4:0] bitn;
        logic [23:0] sh;
        logic [15:0] rd;
        logic [15:0] rdata;
        logic scl;
        logic sda_oe_n;
        logic [1:0] irq_stat;
        logic [1:0] irq_en;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } pm_hst_t;

endpackage

/* src/pm_link_if.sv */
// Two-wire link between host controller and power monitor device
`timescale 1ns/1ps
interface pm_link_if;
    logic scl;
    logic h_sda_o;
    logic h_sda_oe_n;
    logic d_sda_o;
    logic d_sda_oe_n;
    logic sda;

    // Open-drain wire: low while any enabled driver pulls low
    assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);

    modport host (output scl, output h_sda_o, output h_sda_oe_n, input sda);
    modport dev (input scl, output d_sda_o, output d_sda_oe_n, input sda);
endinterface

/* src/pm_device.sv */
// Power monitor device: link slave, averaging, scaling, accumulators and limit checks
`timescale 1ns/1ps
`include "pm_regs.svh"

// Operation
// - Eight conversion periods; sample every period, result every period times count
// - Eight averaging counts from one to 1024
// - Power-up loads both configuration registers
// - Default converts temperature, current, voltage continuously
// - Host rewrites configuration after each power cycle
// - Current limits 16 bits, voltage limits 15 bits, coarser
// - Power limit 16 bits against 24-bit power
// - Power cycle restores limits; host reprograms them
// - Signed results in two's complement
// - Host scales current limit by sixteen LSBs
// - Fixed weights per result LSB
// - Bus voltage compared against overvoltage limit
// - Latched done flag cleared by read or trigger
// - Energy wraps; accumulator reset clears both
// - Charge overflow flags and freezes until reset
module pm_device #(
    parameter int CYCLES_PER_US = `PM_CLK_MHZ
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    pm_link_if.dev lnk,
    // Front end
    output logic conv_req,
    input wire logic [19:0] cur_sample,
    input wire logic [19:0] vbus_sample,
    input wire logic [15:0] temp_sample,
    // Status
    output logic result_valid,
    output logic alert
);

    initial begin
        if (CYCLES_PER_US < 1 || CYCLES_PER_US > 4072) begin
            $error("pm_device: CYCLES_PER_US out of range");
        end
    end

    pm_pkg::pm_dev_t s;
    pm_pkg::pm_dev_t next_s;

    logic rise, fall, start, stop, wr, clr_rd, acc_rst, trig, tick, last;
    logic [3:0] sh;
    logic [6:0] idx;
    logic [29:0] t_cur, t_vb, t_tmp;
    logic [19:0] a_cur, a_vb, ac;
    logic [15:0] a_tmp;
    logic [37:0] prod;
    logic [23:0] p24;
    logic [39:0] c_add, c_sum;
    logic c_ovf;
    logic [7:0] ev, keep;

    // ==========================================
    // Decoders
    function automatic logic [23:0] conv_cycles(input logic [2:0] sel);
        logic [12:0] us;
        unique case (sel)
            3'h0: us = `PM_T_CONV0_US;
            3'h1: us = `PM_T_CONV1_US;
            3'h2: us = `PM_T_CONV2_US;
            3'h3: us = `PM_T_CONV3_US;
            3'h4: us = `PM_T_CONV4_US;
            3'h5: us = `PM_T_CONV5_US;
            3'h6: us = `PM_T_CONV6_US;
            3'h7: us = `PM_T_CONV7_US;
        endcase
        return 24'(us * CYCLES_PER_US);
    endfunction

    // Log2 of the averaging count
    function automatic logic [3:0] avg_shift(input logic [2:0] sel);
        unique case (sel)
            3'h0: return 4'h0;
            3'h1: return 4'h2;
            3'h2: return 4'h4;
            3'h3: return 4'h6;
            3'h4: return 4'h7;
            3'h5: return 4'h8;
            3'h6: return 4'h9;
            3'h7: return 4'ha;
        endcase
    endfunction

    function automatic logic [15:0] rd_mux(input logic [6:0] a, input pm_pkg::pm_dev_t d);
        unique case (a)
            `PM_R_CONFIG: return {13'h0000, d.trig_busy, d.latch, 1'b0};
            `PM_R_ADC_CONFIG: return {9'h000, d.avg_sel, d.conv_sel, d.cont};
            `PM_R_VBUS: return d.vb[19:4];
            `PM_R_TEMP: return d.tmp;
            `PM_R_CURRENT: return d.cur[19:4];
            `PM_R_POWER: return d.pwr[23:8];
            `PM_R_ENERGY: return d.energy[39:24];
            `PM_R_CHARGE: return d.charge[39:24];
            `PM_R_DIAG: return {8'h00, d.diag};
            `PM_R_COL: return d.col;
            `PM_R_CUL: return d.cul;
            `PM_R_BUS_OVERVOLTAGE_LIMIT: return {1'b0, d.bus_overvoltage_limit};
            `PM_R_BUVL: return {1'b0, d.buvl};
            `PM_R_TOL: return d.tol;
            `PM_R_POL: return d.pol;
            default: return 16'h0000;
        endcase
    endfunction

    always_comb begin
        next_s = s;
        // ==========================================
        // Link receiver
        next_s.scl_m = lnk.scl;
        next_s.scl_s = s.scl_m;
        next_s.scl_d = s.scl_s;
        next_s.sda_m = lnk.sda;
        next_s.sda_s = s.sda_m;
        next_s.sda_d = s.sda_s;
        rise = s.scl_s & ~s.scl_d;
        fall = ~s.scl_s & s.scl_d;
        start = s.scl_s & s.scl_d & ~s.sda_s & s.sda_d;
        stop = s.scl_s & s.scl_d & s.sda_s & ~s.sda_d;
        idx = {s.regi[5:0], s.sda_s};
        wr = 1'b0;
        clr_rd = 1'b0;
        if (start) begin
            next_s.in_frame = 1'b1;
            next_s.bitcnt = 5'd0;
            next_s.sda_oe_n = 1'b1;
        end else if (stop) begin
            next_s.in_frame = 1'b0;
            next_s.sda_oe_n = 1'b1;
            wr = s.in_frame & ~s.rw & (s.bitcnt == 5'd24);
        end else if (s.in_frame && rise && s.bitcnt != 5'd24) begin
            next_s.bitcnt = 5'(s.bitcnt + 5'd1);
            if (s.bitcnt == 5'd0) begin
                next_s.rw = s.sda_s;
            end else if (s.bitcnt < 5'd8) begin
                next_s.regi = idx;
            end else if (!s.rw) begin
                next_s.wdat = {s.wdat[14:0], s.sda_s};
            end
            if (s.bitcnt == 5'd7) begin
                next_s.rdat = rd_mux(idx, s);
                clr_rd = s.rw & (idx == `PM_R_DIAG) & s.latch;
            end
        end else if (s.in_frame && fall) begin
            if (s.rw && s.bitcnt >= 5'd8 && s.bitcnt < 5'd24) begin
                next_s.sda_oe_n = s.rdat[15];
                next_s.rdat = {s.rdat[14:0], 1'b1};
            end else begin
                next_s.sda_oe_n = 1'b1;
            end
        end

        // ==========================================
        // Register writes
        acc_rst = 1'b0;
        trig = 1'b0;
        if (wr) begin
            unique case (s.regi)
                `PM_R_CONFIG: begin
                    next_s.latch = s.wdat[`PM_CFG_LATCH];
                    acc_rst = s.wdat[`PM_CFG_ACC_RST];
                    trig = s.wdat[`PM_CFG_TRIG];
                end
                `PM_R_ADC_CONFIG: begin
                    next_s.cont = s.wdat[`PM_ADC_CONT];
                    next_s.conv_sel = s.wdat[3:1];
                    next_s.avg_sel = s.wdat[6:4];
                end
                `PM_R_COL: next_s.col = s.wdat;
                `PM_R_CUL: next_s.cul = s.wdat;
                `PM_R_BUS_OVERVOLTAGE_LIMIT: next_s.bus_overvoltage_limit = s.wdat[14:0];
                `PM_R_BUVL: next_s.buvl = s.wdat[14:0];
                `PM_R_TOL: next_s.tol = s.wdat;
                `PM_R_POL: next_s.pol = s.wdat;
                default: ;
            endcase
        end

        // ==========================================
        // Conversion and averaging engine
        sh = avg_shift(s.avg_sel);
        tick = (s.cont | s.trig_busy) & (s.timer == 24'(conv_cycles(s.conv_sel) - 24'd1));
        last = tick & (11'(s.navg + 11'd1) == 11'(11'd1 << sh));
        t_cur = 30'(s.sum_cur + {{10{cur_sample[19]}}, cur_sample});
        t_vb = 30'(s.sum_vb + {{10{vbus_sample[19]}}, vbus_sample});
        t_tmp = 30'(s.sum_tmp + {{14{temp_sample[15]}}, temp_sample});
        a_cur = 20'($signed(t_cur) >>> sh);
        a_vb = 20'($signed(t_vb) >>> sh);
        a_tmp = 16'($signed(t_tmp) >>> sh);
        ac = a_cur[19] ? 20'(~a_cur + 20'd1) : a_cur;
        prod = 38'(ac[18:0]) * 38'(a_vb[18:0]);
        p24 = prod[37:14];
        c_add = {{20{a_cur[19]}}, a_cur};
        c_sum = 40'(s.charge + c_add);
        c_ovf = (s.charge[39] == c_add[39]) & (c_sum[39] != s.charge[39]);
        ev = {$signed(a_tmp) > $signed(s.tol),
              p24[23:8] > s.pol,
              $signed(a_vb[19:4]) < $signed({1'b0, s.buvl}),
              $signed(a_vb[19:4]) > $signed({1'b0, s.bus_overvoltage_limit}),
              $signed(a_cur[19:4]) < $signed(s.cul),
              $signed(a_cur[19:4]) > $signed(s.col),
              1'b0, 1'b1};
        next_s.conv_req = tick;
        next_s.result_valid = last & ~trig;
        if (trig || (wr && s.regi == `PM_R_ADC_CONFIG)) begin
            next_s.trig_busy = trig;
            next_s.timer = 24'd0;
            next_s.navg = 11'd0;
            next_s.sum_cur = 30'd0;
            next_s.sum_vb = 30'd0;
            next_s.sum_tmp = 30'd0;
        end else if (tick) begin
            next_s.timer = 24'd0;
            if (last) begin
                next_s.navg = 11'd0;
                next_s.sum_cur = 30'd0;
                next_s.sum_vb = 30'd0;
                next_s.sum_tmp = 30'd0;
                next_s.trig_busy = 1'b0;
                next_s.cur = a_cur;
                next_s.vb = a_vb;
                next_s.tmp = a_tmp;
                next_s.pwr = p24;
                next_s.energy = 40'(s.energy + {16'h0000, p24});
                if (!s.diag[1]) begin
                    if (c_ovf) begin
                        next_s.diag[1] = 1'b1;
                    end else begin
                        next_s.charge = c_sum;
                    end
                end
            end else begin
                next_s.navg = 11'(s.navg + 11'd1);
                next_s.sum_cur = t_cur;
                next_s.sum_vb = t_vb;
                next_s.sum_tmp = t_tmp;
            end
        end else if (s.cont || s.trig_busy) begin
            next_s.timer = 24'(s.timer + 24'd1);
        end

        // ==========================================
        // Flags; new result flags win over a read clear in the same cycle but are dropped on a trigger
        keep = 8'hff;
        if (clr_rd) begin
            keep = 8'b0000_0010;
        end
        if (trig) begin
            keep[0] = 1'b0;
        end
        next_s.diag = next_s.diag & keep;
        if (last && !trig) begin
            if (s.latch) begin
                next_s.diag = next_s.diag | {ev[7:2], 1'b0, ev[0]};
            end else begin
                next_s.diag = {ev[7:2], next_s.diag[1], 1'b1};
            end
        end
        if (acc_rst) begin
            next_s.energy = 40'd0;
            next_s.charge = 40'd0;
            next_s.diag[1] = 1'b0;
        end
        next_s.alert = |next_s.diag[7:2];
    end

    // Supply power-up: configuration and limits return to defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.scl_m <= 1'b1;
            s.scl_s <= 1'b1;
            s.scl_d <= 1'b1;
            s.sda_m <= 1'b1;
            s.sda_s <= 1'b1;
            s.sda_d <= 1'b1;
            s.sda_oe_n <= 1'b1;
            s.cont <= 1'b1;
            s.conv_sel <= `PM_RST_CONV_SEL;
            s.avg_sel <= `PM_RST_AVG_SEL;
            s.col <= `PM_RST_COL;
            s.cul <= `PM_RST_CUL;
            s.bus_overvoltage_limit <= `PM_RST_BUS_OVERVOLTAGE_LIMIT;
            s.buvl <= `PM_RST_BUVL;
            s.tol <= `PM_RST_TOL;
            s.pol <= `PM_RST_POL;
        end else begin
            s <= next_s;
        end
    end

    assign lnk.d_sda_o = 1'b0;
    assign lnk.d_sda_oe_n = s.sda_oe_n;
    assign conv_req = s.conv_req;
    assign result_valid = s.result_valid;
    assign alert = s.alert;

endmodule

/* src/pm_host.sv */
// Host controller: APB command registers driving the two-wire link to the power monitor
`timescale 1ns/1ps
`include "pm_regs.svh"

module pm_host #(
    parameter int HALF = `PM_LINK_HALF
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Link
    pm_link_if.host lnk
);

    initial begin
        if (HALF < 4 || HALF > 255) begin
            $error("pm_host: HALF out of range");
        end
    end

    pm_pkg::pm_hst_t s;
    pm_pkg::pm_hst_t next_s;
    logic done, acc, fire, is_rd;
    logic [23:0] nsh;

    always_comb begin
        next_s = s;
        next_s.sda_m = lnk.sda;
        next_s.sda_s = s.sda_m;
        // ==========================================
        // APB slave, one wait state
        acc = psel & penable;
        fire = 1'b0;
        next_s.pready = acc & ~s.pready;
        if (acc && !s.pready) begin
            next_s.pslverr = 1'b0;
            unique case (paddr)
                `PM_A_STATUS: next_s.prdata = {31'h0, s.st != pm_pkg::PM_IDLE};
                `PM_A_RDATA: next_s.prdata = {16'h0000, s.rdata};
                `PM_A_IRQ_STAT: next_s.prdata = {30'h0, s.irq_stat};
                `PM_A_IRQ_EN: next_s.prdata = {30'h0, s.irq_en};
                `PM_A_CMD, `PM_A_IRQ_CLR: next_s.prdata = 32'h0000_0000;
                default: begin
                    next_s.prdata = 32'h0000_0000;
                    next_s.pslverr = 1'b1;
                end
            endcase
        end
        if (acc && s.pready && pwrite) begin
            unique case (paddr)
                `PM_A_CMD: fire = 1'b1;
                `PM_A_IRQ_CLR: next_s.irq_stat = s.irq_stat & ~pwdata[1:0];
                `PM_A_IRQ_EN: next_s.irq_en = pwdata[1:0];
                default: ;
            endcase
        end

        // ==========================================
        // Link master; limits and configuration are relayed as software orders
        done = s.cnt == 8'(HALF - 1);
        next_s.cnt = done ? 8'h00 : 8'(s.cnt + 8'h01);
        is_rd = s.sh[23] | (s.bitn >= 5'd8 && s.rd[15] == 1'b0 && 1'b0);
        nsh = {s.sh[22:0], 1'b0};
        unique case (s.st)
            pm_pkg::PM_IDLE: begin
                next_s.cnt = 8'h00;
                if (fire) begin
                    next_s.sh = pwdata[23:0];
                    next_s.sda_oe_n = 1'b0;
                    next_s.st = pm_pkg::PM_START;
                end
            end
            pm_pkg::PM_START: begin
                if (done) begin
                    next_s.scl = 1'b0;
                    next_s.bitn = 5'd0;
                    next_s.sda_oe_n = s.sh[23];
                    next_s.st = pm_pkg::PM_LOW;
                end
            end
            pm_pkg::PM_LOW: begin
                if (done) begin
                    next_s.scl = 1'b1;
                    next_s.st = pm_pkg::PM_HIGH;
                end
            end
            pm_pkg::PM_HIGH: begin
                if (done) begin
                    next_s.rd = {s.rd[14:0], s.sda_s};
                    next_s.scl = 1'b0;
                    next_s.bitn = 5'(s.bitn + 5'd1);
                    if (s.bitn == 5'd0) begin
                        next_s.sh = {s.sh[23], nsh[22:0]};
                    end else begin
                        next_s.sh = {s.sh[23], nsh[22:0]};
                    end
                    if (s.bitn == 5'd23) begin
                        next_s.sda_oe_n = 1'b0;
                        next_s.st = pm_pkg::PM_STOP_LOW;
                    end else begin
                        next_s.sda_oe_n = (s.sh[23] && s.bitn >= 5'd7) ? 1'b1 : s.sh[22];
                        next_s.st = pm_pkg::PM_LOW;
                    end
                end
            end
            pm_pkg::PM_STOP_LOW: begin
                if (done) begin
                    next_s.scl = 1'b1;
                    next_s.st = pm_pkg::PM_STOP_HIGH;
                end
            end
            pm_pkg::PM_STOP_HIGH: begin
                if (done) begin
                    next_s.sda_oe_n = 1'b1;
                    next_s.st = pm_pkg::PM_STOP_REL;
                end
            end
            pm_pkg::PM_STOP_REL: begin
                if (done) begin
                    next_s.rdata = is_rd ? s.rd : s.rdata;
                    next_s.irq_stat[0] = 1'b1;
                    next_s.st = pm_pkg::PM_IDLE;
                end
            end
            default: next_s.st = pm_pkg::PM_IDLE;
        endcase
        if (fire && s.st != pm_pkg::PM_IDLE) begin
            next_s.irq_stat[1] = 1'b1;
        end
        next_s.irq = |(next_s.irq_stat & next_s.irq_en);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.st <= pm_pkg::PM_IDLE;
            s.sda_m <= 1'b1;
            s.sda_s <= 1'b1;
            s.scl <= 1'b1;
            s.sda_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
    assign lnk.scl = s.scl;
    assign lnk.h_sda_o = 1'b0;
    assign lnk.h_sda_oe_n = s.sda_oe_n;

endmodule

/* test/pm_link_monitor.sv */
// Link protocol checker for the power monitor pair
`timescale 1ns/1ps
module pm_link_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic scl,
    input wire logic h_sda_o,
    input wire logic h_sda_oe_n,
    input wire logic d_sda_o,
    input wire logic d_sda_oe_n,
    input wire logic sda
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========================================
    // Frame edges
    sequence s_start;
        scl && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $rose(sda);
    endsequence
    a_reset_idle: assert property ($rose(presetn) |-> scl && h_sda_oe_n && d_sda_oe_n)
        else $error("link driven after reset");
    a_open_drain: assert property (h_sda_o == 1'b0 && d_sda_o == 1'b0)
        else $error("data driven high");
    a_scl_low_half: assert property ($fell(scl) |-> !scl [*8] ##1 scl)
        else $error("clock low phase wrong");
    a_scl_high_half: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase short");
    a_host_bit_steady: assert property ($rose(scl) |=> $stable(h_sda_oe_n) [*6])
        else $error("host data moved in high phase");
    a_dev_bit_steady: assert property ($rose(scl) |=> $stable(d_sda_oe_n) [*6])
        else $error("device data moved in high phase");
    a_frame_bound: assert property (s_start |-> ##[300:1000] s_stop)
        else $error("frame did not end");
    a_dev_release: assert property ($fell(d_sda_oe_n) |-> ##[1:300] d_sda_oe_n)
        else $error("device held data line");
endmodule

/* test/power_monitor_limit_scaling_test.sv */
// Bench for the power monitor host and device pair
`timescale 1ns/1ps
`include "pm_regs.svh"
module power_monitor_limit_scaling_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er, irq, pready, pslverr, conv_req, result_valid, alert;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'ha0fae7ed;
    logic [19:0] cur = 20'h0, vb = 20'h0, ca = 20'h0, cb = 20'h0;
    logic [14:0] lim;
    logic [6:0] ri[8] = '{7'h00, 7'h01, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h11};
    logic [15:0] rv[8] = '{16'h0, 16'h000b, 16'h7fff, 16'h8000, 16'h7fff, 16'h0, 16'h07ff, 16'h0fff};
    int tc[8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
    int an[5] = '{1, 4, 16, 64, 128};
    int failures = 0, samples_checked = 0, gap = 0, rgap = 0, per = 0, rper = 0;
    always #5 pclk = ~pclk;
    pm_link_if lnk ();
    pm_host i_pm_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .lnk(lnk));
    pm_device #(.CYCLES_PER_US(1)) i_pm_device (.pclk(pclk), .presetn(presetn), .lnk(lnk), .conv_req(conv_req),
        .cur_sample(cur), .vbus_sample(vb), .temp_sample(16'h0), .result_valid(result_valid), .alert(alert));
    pm_link_monitor i_pm_link_monitor (.pclk(pclk), .presetn(presetn), .scl(lnk.scl), .h_sda_o(lnk.h_sda_o),
        .h_sda_oe_n(lnk.h_sda_oe_n), .d_sda_o(lnk.d_sda_o), .d_sda_oe_n(lnk.d_sda_oe_n), .sda(lnk.sda));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Mean of two alternating samples, top sixteen bits
    function automatic logic [15:0] mean16(input logic [19:0] a, input logic [19:0] b);
        logic [20:0] s;
        s = {a[19], a} + {b[19], b};
        return s[20:5];
    endfunction
    task automatic stop_test();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (n >= 50) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic cmd(input logic r, input logic [6:0] i, input logic [15:0] d);
        int n;
        apb(1'b1, `PM_A_CMD, {8'h0, r, i, d});
        n = 0;
        do begin
            apb(1'b0, `PM_A_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 400);
        apb(1'b0, `PM_A_RDATA, 32'h0);
        if (n >= 400) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic wait_ev(input logic w);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((w ? result_valid : conv_req) !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic rst_chk();
        for (int k = 0; k < 8; k++) begin
            cmd(1'b1, ri[k], 16'h0);
            chk("reset value", rd[15:0], rv[k]);
        end
    endtask
    // Front end alternates two levels so any even window averages to their mean
    always @(posedge pclk) begin
        if (conv_req === 1'b1) begin
            cur <= (cur === ca) ? cb : ca;
        end
        gap <= (conv_req === 1'b1) ? 0 : gap + 1;
        rgap <= (result_valid === 1'b1) ? 0 : rgap + 1;
        if (conv_req === 1'b1 && per != 0) chk("tick period", gap + 1, per);
        if (result_valid === 1'b1 && rper != 0) chk("result period", rgap + 1, rper);
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        wait_ev(1'b1);
        rper <= 1052;
        wait_ev(1'b1);
        rper <= 0;
        rst_chk();
        for (int k = 1; k < 8; k++) begin
            seed = xs(seed);
            cmd(1'b0, ri[k], seed[15:0]);
        end
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rst_chk();
        for (int k = 0; k < 8; k++) begin
            cmd(1'b0, `PM_R_ADC_CONFIG, {9'h0, 3'h0, k[2:0], 1'b1});
            wait_ev(1'b0);
            per <= tc[k];
            wait_ev(1'b0);
            per <= 0;
        end
        for (int k = 1; k < 5; k++) begin
            seed = xs(seed);
            ca <= seed[19:0];
            cb <= seed[31:12];
            cmd(1'b0, `PM_R_ADC_CONFIG, {9'h0, k[2:0], 3'h0, 1'b1});
            wait_ev(1'b1);
            rper <= 50 * an[k];
            wait_ev(1'b1);
            rper <= 0;
            cmd(1'b1, `PM_R_CURRENT, 16'h0);
            chk("mean current", rd[15:0], mean16(ca, cb));
        end
        {ca, cb} <= 40'h0;
        vb <= {2'b01, seed[17:0]};
        cmd(1'b0, `PM_R_ADC_CONFIG, 16'h0001);
        for (int k = 0; k < 2; k++) begin
            lim = k ? vb[18:4] + 15'h1 : vb[18:4] - 15'h1;
            cmd(1'b0, `PM_R_BUS_OVERVOLTAGE_LIMIT, {1'b0, lim});
            repeat (2) wait_ev(1'b1);
            cmd(1'b1, `PM_R_DIAG, 16'h0);
            chk("overvoltage", rd[4], vb[18:4] > lim);
            chk("alert", alert, vb[18:4] > lim);
        end
        apb(1'b1, `PM_A_IRQ_EN, 32'h1);
        @(posedge pclk);
        chk("irq raised", irq, 1'b1);
        apb(1'b1, `PM_A_IRQ_CLR, 32'h3);
        apb(1'b1, `PM_A_IRQ_EN, 32'h0);
        apb(1'b1, `PM_A_CMD, 32'h0080_0000);
        cmd(1'b1, 7'h0c, 16'h0);
        apb(1'b0, `PM_A_IRQ_STAT, 32'h0);
        chk("irq status", rd, 32'h3);
        chk("irq masked", irq, 1'b0);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", {rd[30:0], er}, 32'h1);
        stop_test();
    end
endmodule
